// File: include/sync_cfg_pkg.sv
/*
  constants for the sync configuration checker: register indices, fields,
  codes, reset values and timing.
  assumes a 40 MHz pclk and word-aligned apb addressing (byte address = 4 * index).
*/
package sync_cfg_pkg;
  // apb geometry
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_RX_START = 12'h810;
  localparam logic [11:0] IDX_RX_LEN = 12'h812;
  localparam logic [11:0] IDX_RX_CTL = 12'h814;
  localparam logic [11:0] IDX_TX_START = 12'h818;
  localparam logic [11:0] IDX_TX_LEN = 12'h81a;
  localparam logic [11:0] IDX_TX_CTL = 12'h81c;
  localparam logic [11:0] IDX_ACT = 12'h981;
  localparam logic [11:0] IDX_SYNC_OUT = 12'ha00;
  localparam logic [11:0] IDX_SYNC_IN = 12'ha01;
  localparam logic [11:0] IDX_MBX0_START = 12'ha02;
  localparam logic [11:0] IDX_MBX0_LEN = 12'ha03;
  localparam logic [11:0] IDX_MBX1_START = 12'ha04;
  localparam logic [11:0] IDX_MBX1_LEN = 12'ha05;
  localparam logic [11:0] IDX_PD_LO = 12'ha06;
  localparam logic [11:0] IDX_PD_HI = 12'ha07;
  localparam logic [11:0] IDX_RX_PDO = 12'ha08;
  localparam logic [11:0] IDX_TX_PDO = 12'ha09;
  localparam logic [11:0] IDX_STATE_REQ = 12'ha0a;
  localparam logic [11:0] IDX_STATUS = 12'ha0b;
  localparam logic [11:0] IDX_ALARM_CLR = 12'ha0c;
  localparam logic [11:0] IDX_IRQ_STAT = 12'ha0d;
  localparam logic [11:0] IDX_IRQ_EN = 12'ha0e;
  localparam logic [11:0] IDX_IRQ_CLR = 12'ha0f;
  // reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_PD_HI = 16'hffff;
  // sync mode codes
  localparam logic [7:0] SM_FREE = 8'h00;
  localparam logic [7:0] SM_OUT_BUF = 8'h01;
  localparam logic [7:0] SM_PULSE = 8'h02;
  localparam logic [7:0] SM_IN_BUF = 8'h22;
  localparam logic [2:0] ACT_OFF = 3'b000;
  // buffer control direction field
  localparam int DIR_HI = 3;
  localparam int DIR_LO = 2;
  localparam logic [1:0] RX_DIR = 2'b01;
  localparam logic [1:0] TX_DIR = 2'b00;
  // state request / state report codes
  localparam logic [3:0] ST_CODE_PREOP = 4'h2;
  localparam logic [3:0] ST_CODE_SAFEOP = 4'h4;
  localparam logic [3:0] ST_CODE_OP = 4'h8;
  // status codes
  localparam logic [15:0] AL_NONE = 16'h0000;
  localparam logic [15:0] AL_SYNC = 16'h0028;
  localparam logic [15:0] AL_RX = 16'h001d;
  localparam logic [15:0] AL_TX = 16'h001e;
  // status register fields
  localparam int STAT_SYNC_BIT = 4;
  localparam int STAT_BM_BIT = 5;
  localparam int STAT_CODE_LO = 16;
  // interrupt bits
  localparam int IRQ_W = 3;
  localparam int IRQ_SYNC = 0;
  localparam int IRQ_RX = 1;
  localparam int IRQ_TX = 2;
  // error indicator blink half period
  localparam int unsigned CLK_KHZ = 40000;
  localparam int unsigned BLINK_HALF_MS = 200;
  localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_MS * CLK_KHZ;
  localparam int BLINK_W = 23;
  typedef enum logic [1:0] {ST_PREOP, ST_CHECK, ST_SAFEOP, ST_OP} state_t;
  typedef enum logic [1:0] {AK_NONE, AK_SYNC, AK_RX, AK_TX} alarm_t;
endpackage

// File: hw/sync_config_checker.sv
/*
  sync configuration checker: apb register file, state machine, config checks,
  sticky alarm, error indicator blink and interrupt.
  assumes an apb3 master on pclk; all other inputs synchronous to pclk.
*/
// Added by the designer: the APB register port.
// How it works
// [R1] output sync mode must be free-running, buffer-event or sync pulse, else sync alarm
// [R2] input sync mode must be free-running, sync pulse or buffer-event, else sync alarm
// [R3] with activation bits zero, buffer-event in only one object is a sync alarm
// [R4] master should write the same sync mode into both objects
// [R5] sync mode checks run only during the preop to safeop transition
// [R6] buffer checks run during that transition and in safeop and op
// [R7] any of these errors returns or holds the state machine in preop
// [R8] report 0028h, 001dh or 001eh for sync, receive and transmit errors
// [R9] error indicator blinks while one of these alarms is active
// [R10] odd receive or transmit buffer start address is a buffer error
// [R11] overlapping receive and transmit areas are a buffer error
// [R12] either mailbox overlapping either process-data area is a buffer error
// [R13] process-data start address outside permitted memory range is a buffer error
// [R14] receive length differing from mapped receive size is a receive error
// [R15] transmit length differing from mapped transmit size is a transmit error
// [R16] receive control bits 3 to 2 must read 01b
// [R17] transmit control bits 3 to 2 must read 00b
// [R18] first alarm and its code stay latched until cleared; later ones ignored
module sync_config_checker #(
  parameter int unsigned BLINK_HALF_CYCLES = sync_cfg_pkg::BLINK_HALF_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sync_cfg_pkg::ADDR_W-1:0] paddr,
  input wire logic [sync_cfg_pkg::DATA_W-1:0] pwdata,
  output logic [sync_cfg_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // device status
  output logic irq,
  output logic err_led,
  output logic [3:0] esm_state,
  output logic [15:0] al_status_code
);

  function automatic logic overlap(input logic [15:0] as, input logic [15:0] al,
                                   input logic [15:0] bs, input logic [15:0] bl);
    logic [16:0] ae;
    logic [16:0] be;
    ae = {1'b0, as} + {1'b0, al};
    be = {1'b0, bs} + {1'b0, bl};
    return (al != 16'h0000) && (bl != 16'h0000) && ({1'b0, as} < be) && ({1'b0, bs} < ae);
  endfunction

  function automatic logic out_of_range(input logic [15:0] s, input logic [15:0] lo,
                                        input logic [15:0] hi);
    return (s < lo) || (s > hi);
  endfunction

  // configuration registers
  logic [15:0] rx_start_r, rx_len_r, tx_start_r, tx_len_r;
  logic [7:0] rx_ctl_r, tx_ctl_r, act_r, sync_out_r, sync_in_r;
  logic [15:0] mbx0_start_r, mbx0_len_r, mbx1_start_r, mbx1_len_r;
  logic [15:0] pd_lo_r, pd_hi_r, rx_pdo_r, tx_pdo_r;
  logic [3:0] req_code_r;
  logic req_new_r;
  logic [sync_cfg_pkg::IRQ_W-1:0] irq_stat_r, irq_en_r, irq_stat_nxt;
  sync_cfg_pkg::state_t state_r, state_nxt;
  sync_cfg_pkg::alarm_t alarm_r, alarm_nxt;
  logic [sync_cfg_pkg::BLINK_W-1:0] blink_cnt_r;
  logic [31:0] rd_data;
  logic rd_hit;

  // apb decode
  wire [11:0] idx = paddr[13:2];
  wire addr_ok = (paddr[15:14] == 2'b00) && (paddr[1:0] == 2'b00);
  wire access = psel && penable;
  wire wr_en = access && pready && pwrite && addr_ok && rd_hit;
  wire wr_state = wr_en && (idx == sync_cfg_pkg::IDX_STATE_REQ);
  wire clr_alarm = wr_en && (idx == sync_cfg_pkg::IDX_ALARM_CLR) && pwdata[0];
  wire wr_irq_clr = wr_en && (idx == sync_cfg_pkg::IDX_IRQ_CLR);

  // checks
  wire out_bad = (sync_out_r != sync_cfg_pkg::SM_FREE) && (sync_out_r != sync_cfg_pkg::SM_OUT_BUF)
                 && (sync_out_r != sync_cfg_pkg::SM_PULSE); // see [R1]
  wire in_bad = (sync_in_r != sync_cfg_pkg::SM_FREE) && (sync_in_r != sync_cfg_pkg::SM_PULSE)
                && (sync_in_r != sync_cfg_pkg::SM_IN_BUF); // see [R2]
  wire pair_bad = (act_r[2:0] == sync_cfg_pkg::ACT_OFF)
                  && ((sync_out_r == sync_cfg_pkg::SM_OUT_BUF) != (sync_in_r == sync_cfg_pkg::SM_IN_BUF)); // see [R3]
  wire sync_err = out_bad || in_bad || pair_bad;
  wire shared_bad = overlap(rx_start_r, rx_len_r, tx_start_r, tx_len_r); // see [R11]
  wire rx_mbx = overlap(rx_start_r, rx_len_r, mbx0_start_r, mbx0_len_r)
                || overlap(rx_start_r, rx_len_r, mbx1_start_r, mbx1_len_r); // see [R12]
  wire tx_mbx = overlap(tx_start_r, tx_len_r, mbx0_start_r, mbx0_len_r)
                || overlap(tx_start_r, tx_len_r, mbx1_start_r, mbx1_len_r); // see [R12]
  wire rx_err = rx_start_r[0] || shared_bad || rx_mbx // see [R10]
                || out_of_range(rx_start_r, pd_lo_r, pd_hi_r) // see [R13]
                || (rx_len_r != rx_pdo_r) // see [R14]
                || (rx_ctl_r[sync_cfg_pkg::DIR_HI:sync_cfg_pkg::DIR_LO] != sync_cfg_pkg::RX_DIR); // see [R16]
  wire tx_err = tx_start_r[0] || shared_bad || tx_mbx // see [R10]
                || out_of_range(tx_start_r, pd_lo_r, pd_hi_r) // see [R13]
                || (tx_len_r != tx_pdo_r) // see [R15]
                || (tx_ctl_r[sync_cfg_pkg::DIR_HI:sync_cfg_pkg::DIR_LO] != sync_cfg_pkg::TX_DIR); // see [R17]
  wire bm_active = (state_r != sync_cfg_pkg::ST_PREOP); // see [R6]
  wire sync_evt = (state_r == sync_cfg_pkg::ST_CHECK) && sync_err; // see [R5]
  wire rx_evt = bm_active && rx_err;
  wire tx_evt = bm_active && tx_err;
  wire any_evt = sync_evt || rx_evt || tx_evt;
  wire alarm_on = (alarm_r != sync_cfg_pkg::AK_NONE);

  // state machine
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      sync_cfg_pkg::ST_PREOP: begin
        if (req_new_r && req_code_r == sync_cfg_pkg::ST_CODE_SAFEOP) begin
          state_nxt = sync_cfg_pkg::ST_CHECK;
        end
      end
      sync_cfg_pkg::ST_CHECK: begin
        state_nxt = any_evt ? sync_cfg_pkg::ST_PREOP : sync_cfg_pkg::ST_SAFEOP; // see [R7]
      end
      sync_cfg_pkg::ST_SAFEOP: begin
        if (any_evt) begin
          state_nxt = sync_cfg_pkg::ST_PREOP; // see [R7]
        end else if (req_new_r && req_code_r == sync_cfg_pkg::ST_CODE_OP) begin
          state_nxt = sync_cfg_pkg::ST_OP;
        end else if (req_new_r && req_code_r == sync_cfg_pkg::ST_CODE_PREOP) begin
          state_nxt = sync_cfg_pkg::ST_PREOP;
        end
      end
      sync_cfg_pkg::ST_OP: begin
        if (any_evt || (req_new_r && req_code_r == sync_cfg_pkg::ST_CODE_PREOP)) begin
          state_nxt = sync_cfg_pkg::ST_PREOP; // see [R7]
        end else if (req_new_r && req_code_r == sync_cfg_pkg::ST_CODE_SAFEOP) begin
          state_nxt = sync_cfg_pkg::ST_SAFEOP;
        end
      end
      default: state_nxt = sync_cfg_pkg::ST_PREOP;
    endcase
  end

  // first alarm latched, new one beats a clear in the same cycle
  always_comb begin
    alarm_nxt = clr_alarm ? sync_cfg_pkg::AK_NONE : alarm_r;
    if (!alarm_on || clr_alarm) begin // see [R18]
      if (sync_evt) begin
        alarm_nxt = sync_cfg_pkg::AK_SYNC;
      end else if (rx_evt) begin
        alarm_nxt = sync_cfg_pkg::AK_RX;
      end else if (tx_evt) begin
        alarm_nxt = sync_cfg_pkg::AK_TX;
      end
    end
  end

  wire [15:0] code_nxt = (alarm_nxt == sync_cfg_pkg::AK_SYNC) ? sync_cfg_pkg::AL_SYNC :
                         (alarm_nxt == sync_cfg_pkg::AK_RX) ? sync_cfg_pkg::AL_RX :
                         (alarm_nxt == sync_cfg_pkg::AK_TX) ? sync_cfg_pkg::AL_TX :
                         sync_cfg_pkg::AL_NONE; // see [R8]
  wire [3:0] code_state = (state_nxt == sync_cfg_pkg::ST_SAFEOP) ? sync_cfg_pkg::ST_CODE_SAFEOP :
                          (state_nxt == sync_cfg_pkg::ST_OP) ? sync_cfg_pkg::ST_CODE_OP :
                          sync_cfg_pkg::ST_CODE_PREOP;
  wire [sync_cfg_pkg::IRQ_W-1:0] evt_vec = {tx_evt, rx_evt, sync_evt};
  wire [sync_cfg_pkg::IRQ_W-1:0] clr_vec = wr_irq_clr ? pwdata[sync_cfg_pkg::IRQ_W-1:0] : '0;
  wire blink_end = (blink_cnt_r == sync_cfg_pkg::BLINK_W'(BLINK_HALF_CYCLES - 1));

  always_comb begin
    irq_stat_nxt = (irq_stat_r & ~clr_vec) | evt_vec;
  end

  // read mux
  always_comb begin
    rd_hit = 1'b1;
    rd_data = 32'h0000_0000;
    case (idx)
      sync_cfg_pkg::IDX_RX_START: rd_data[15:0] = rx_start_r;
      sync_cfg_pkg::IDX_RX_LEN: rd_data[15:0] = rx_len_r;
      sync_cfg_pkg::IDX_RX_CTL: rd_data[7:0] = rx_ctl_r;
      sync_cfg_pkg::IDX_TX_START: rd_data[15:0] = tx_start_r;
      sync_cfg_pkg::IDX_TX_LEN: rd_data[15:0] = tx_len_r;
      sync_cfg_pkg::IDX_TX_CTL: rd_data[7:0] = tx_ctl_r;
      sync_cfg_pkg::IDX_ACT: rd_data[7:0] = act_r;
      sync_cfg_pkg::IDX_SYNC_OUT: rd_data[7:0] = sync_out_r;
      sync_cfg_pkg::IDX_SYNC_IN: rd_data[7:0] = sync_in_r;
      sync_cfg_pkg::IDX_MBX0_START: rd_data[15:0] = mbx0_start_r;
      sync_cfg_pkg::IDX_MBX0_LEN: rd_data[15:0] = mbx0_len_r;
      sync_cfg_pkg::IDX_MBX1_START: rd_data[15:0] = mbx1_start_r;
      sync_cfg_pkg::IDX_MBX1_LEN: rd_data[15:0] = mbx1_len_r;
      sync_cfg_pkg::IDX_PD_LO: rd_data[15:0] = pd_lo_r;
      sync_cfg_pkg::IDX_PD_HI: rd_data[15:0] = pd_hi_r;
      sync_cfg_pkg::IDX_RX_PDO: rd_data[15:0] = rx_pdo_r;
      sync_cfg_pkg::IDX_TX_PDO: rd_data[15:0] = tx_pdo_r;
      sync_cfg_pkg::IDX_STATE_REQ: rd_data[3:0] = req_code_r;
      sync_cfg_pkg::IDX_STATUS: begin
        rd_data[3:0] = esm_state;
        rd_data[sync_cfg_pkg::STAT_SYNC_BIT] = (alarm_r == sync_cfg_pkg::AK_SYNC);
        rd_data[sync_cfg_pkg::STAT_BM_BIT] = (alarm_r == sync_cfg_pkg::AK_RX) || (alarm_r == sync_cfg_pkg::AK_TX);
        rd_data[31:sync_cfg_pkg::STAT_CODE_LO] = al_status_code;
      end
      sync_cfg_pkg::IDX_ALARM_CLR: rd_data = 32'h0000_0000;
      sync_cfg_pkg::IDX_IRQ_STAT: rd_data[sync_cfg_pkg::IRQ_W-1:0] = irq_stat_r;
      sync_cfg_pkg::IDX_IRQ_EN: rd_data[sync_cfg_pkg::IRQ_W-1:0] = irq_en_r;
      sync_cfg_pkg::IDX_IRQ_CLR: rd_data = 32'h0000_0000;
      default: rd_hit = 1'b0;
    endcase
  end

  // apb handshake: one wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= access && !pready;
      pslverr <= access && !pready && !(addr_ok && rd_hit);
      prdata <= (access && !pready && !pwrite && addr_ok) ? rd_data : 32'h0000_0000;
    end
  end

  // register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_start_r <= sync_cfg_pkg::RST_WORD;
      rx_len_r <= sync_cfg_pkg::RST_WORD;
      rx_ctl_r <= sync_cfg_pkg::RST_BYTE;
      tx_start_r <= sync_cfg_pkg::RST_WORD;
      tx_len_r <= sync_cfg_pkg::RST_WORD;
      tx_ctl_r <= sync_cfg_pkg::RST_BYTE;
      act_r <= sync_cfg_pkg::RST_BYTE;
      sync_out_r <= sync_cfg_pkg::RST_BYTE;
      sync_in_r <= sync_cfg_pkg::RST_BYTE;
      mbx0_start_r <= sync_cfg_pkg::RST_WORD;
      mbx0_len_r <= sync_cfg_pkg::RST_WORD;
      mbx1_start_r <= sync_cfg_pkg::RST_WORD;
      mbx1_len_r <= sync_cfg_pkg::RST_WORD;
      pd_lo_r <= sync_cfg_pkg::RST_WORD;
      pd_hi_r <= sync_cfg_pkg::RST_PD_HI;
      rx_pdo_r <= sync_cfg_pkg::RST_WORD;
      tx_pdo_r <= sync_cfg_pkg::RST_WORD;
      irq_en_r <= '0;
    end else if (wr_en) begin
      case (idx)
        sync_cfg_pkg::IDX_RX_START: rx_start_r <= pwdata[15:0];
        sync_cfg_pkg::IDX_RX_LEN: rx_len_r <= pwdata[15:0];
        sync_cfg_pkg::IDX_RX_CTL: rx_ctl_r <= pwdata[7:0];
        sync_cfg_pkg::IDX_TX_START: tx_start_r <= pwdata[15:0];
        sync_cfg_pkg::IDX_TX_LEN: tx_len_r <= pwdata[15:0];
        sync_cfg_pkg::IDX_TX_CTL: tx_ctl_r <= pwdata[7:0];
        sync_cfg_pkg::IDX_ACT: act_r <= pwdata[7:0];
        sync_cfg_pkg::IDX_SYNC_OUT: sync_out_r <= pwdata[7:0];
        sync_cfg_pkg::IDX_SYNC_IN: sync_in_r <= pwdata[7:0];
        sync_cfg_pkg::IDX_MBX0_START: mbx0_start_r <= pwdata[15:0];
        sync_cfg_pkg::IDX_MBX0_LEN: mbx0_len_r <= pwdata[15:0];
        sync_cfg_pkg::IDX_MBX1_START: mbx1_start_r <= pwdata[15:0];
        sync_cfg_pkg::IDX_MBX1_LEN: mbx1_len_r <= pwdata[15:0];
        sync_cfg_pkg::IDX_PD_LO: pd_lo_r <= pwdata[15:0];
        sync_cfg_pkg::IDX_PD_HI: pd_hi_r <= pwdata[15:0];
        sync_cfg_pkg::IDX_RX_PDO: rx_pdo_r <= pwdata[15:0];
        sync_cfg_pkg::IDX_TX_PDO: tx_pdo_r <= pwdata[15:0];
        sync_cfg_pkg::IDX_IRQ_EN: irq_en_r <= pwdata[sync_cfg_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // state, alarm, reporting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_code_r <= sync_cfg_pkg::ST_CODE_PREOP;
      req_new_r <= 1'b0;
      state_r <= sync_cfg_pkg::ST_PREOP;
      alarm_r <= sync_cfg_pkg::AK_NONE;
      esm_state <= sync_cfg_pkg::ST_CODE_PREOP;
      al_status_code <= sync_cfg_pkg::AL_NONE;
      irq_stat_r <= '0;
      irq <= 1'b0;
    end else begin
      req_new_r <= wr_state;
      if (wr_state) begin
        req_code_r <= pwdata[3:0];
      end
      state_r <= state_nxt;
      alarm_r <= alarm_nxt;
      esm_state <= code_state;
      al_status_code <= code_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq <= |(irq_stat_nxt & irq_en_r);
    end
  end

  // error indicator blink
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_cnt_r <= '0;
      err_led <= 1'b0;
    end else if (!alarm_on) begin
      blink_cnt_r <= '0;
      err_led <= 1'b0;
    end else begin
      blink_cnt_r <= blink_end ? '0 : blink_cnt_r + 1'b1;
      err_led <= blink_end ? !err_led : err_led; // see [R9]
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence in_check_s;
    state_r == sync_cfg_pkg::ST_CHECK;
  endsequence
  sequence back_preop_s;
    esm_state == sync_cfg_pkg::ST_CODE_PREOP ##1 state_r == sync_cfg_pkg::ST_PREOP;
  endsequence

  chk_out_mode_bad: assert property (in_check_s and out_bad |=> back_preop_s) // see [R1]
    else $error("bad output sync mode did not return to preop");
  chk_in_mode_bad: assert property (in_check_s and in_bad |=> esm_state == sync_cfg_pkg::ST_CODE_PREOP) // see [R2]
    else $error("bad input sync mode did not return to preop");
  chk_pair_mode: assert property (in_check_s and pair_bad and !alarm_on |=> alarm_r == sync_cfg_pkg::AK_SYNC) // see [R3]
    else $error("unpaired buffer-event mode not flagged");
  chk_sync_scope: assert property (state_r == sync_cfg_pkg::ST_SAFEOP && sync_err && !rx_err && !tx_err
    && !req_new_r |=> state_r == sync_cfg_pkg::ST_SAFEOP) // see [R5]
    else $error("sync check acted outside transition");
  chk_bm_live: assert property (state_r == sync_cfg_pkg::ST_OP && (rx_err || tx_err)
    |=> esm_state == sync_cfg_pkg::ST_CODE_PREOP && state_r == sync_cfg_pkg::ST_PREOP) // see [R6] [R7]
    else $error("buffer error in op did not drop to preop");
  chk_code_sync: assert property (!alarm_on && sync_evt |=> al_status_code == 16'h0028 [*2]) // see [R8]
    else $error("sync status code wrong");
  chk_code_buf: assert property (!alarm_on && !sync_evt && rx_evt |=> al_status_code == 16'h001d) // see [R8]
    else $error("receive status code wrong");
  chk_code_tx: assert property (!alarm_on && !sync_evt && !rx_evt && tx_evt |=> al_status_code == 16'h001e) // see [R8]
    else $error("transmit status code wrong");
  chk_led_blink: assert property (alarm_on && $past(alarm_on) && err_led != $past(err_led)
    |-> $past(blink_cnt_r) == sync_cfg_pkg::BLINK_W'(BLINK_HALF_CYCLES - 1)) // see [R9]
    else $error("indicator toggled off period");
  chk_led_dark: assert property (!alarm_on |=> !err_led) // see [R9]
    else $error("indicator lit without alarm");
  chk_odd_start: assert property (bm_active && (rx_start_r[0] || tx_start_r[0]) |=> state_r == sync_cfg_pkg::ST_PREOP) // see [R10]
    else $error("odd start address not flagged");
  chk_area_rules: assert property (bm_active && (shared_bad || rx_mbx || tx_mbx
    || out_of_range(rx_start_r, pd_lo_r, pd_hi_r)) |=> state_r == sync_cfg_pkg::ST_PREOP) // see [R11] [R12] [R13]
    else $error("area violation not flagged");
  chk_len_dir: assert property (bm_active && !alarm_on && !sync_evt && ((rx_len_r != rx_pdo_r)
    || (rx_ctl_r[3:2] != 2'b01)) |=> alarm_r == sync_cfg_pkg::AK_RX) // see [R14] [R16]
    else $error("receive length or direction not flagged");
  chk_tx_len_dir: assert property (bm_active && !alarm_on && !sync_evt && !rx_err && ((tx_len_r != tx_pdo_r)
    || (tx_ctl_r[3:2] != 2'b00)) |=> alarm_r == sync_cfg_pkg::AK_TX) // see [R15] [R17]
    else $error("transmit length or direction not flagged");
  chk_first_kept: assert property (alarm_on && !clr_alarm |=> $stable(alarm_r) && $stable(al_status_code)) // see [R18]
    else $error("latched alarm changed without clear");

  sequence alarm_rise_s;
    !alarm_on ##1 alarm_on;
  endsequence

  chk_check_brief: assert property (in_check_s |=> !in_check_s) // see [R5]
    else $error("check state held over a cycle");
  chk_safeop_live: assert property (state_r == sync_cfg_pkg::ST_SAFEOP && (rx_err || tx_err)
    |=> esm_state == sync_cfg_pkg::ST_CODE_PREOP) // see [R6] [R7]
    else $error("buffer error in safeop did not drop to preop");
  chk_code_none: assert property (!alarm_on |-> al_status_code == 16'h0000) // see [R8]
    else $error("status code without alarm");
  chk_sync_code: assert property (alarm_r == sync_cfg_pkg::AK_SYNC |-> al_status_code == 16'h0028) // see [R8]
    else $error("sync alarm with wrong code");
  chk_rx_code: assert property (alarm_r == sync_cfg_pkg::AK_RX |-> al_status_code == 16'h001d) // see [R8]
    else $error("receive alarm with wrong code");
  chk_tx_code: assert property (alarm_r == sync_cfg_pkg::AK_TX |-> al_status_code == 16'h001e) // see [R8]
    else $error("transmit alarm with wrong code");
  chk_led_start: assert property (alarm_rise_s |-> !err_led) // see [R9]
    else $error("indicator lit at alarm start");
endmodule

// File: test/apb_master_model.sv
/*
  apb master standing in for the fieldbus master that configures the drive.
  assumes pclk from the bench and a slave that answers with pready.
*/
module apb_master_model (
  // clock
  input wire logic pclk,
  // apb request
  output logic psel = 1'b0,
  output logic penable = 1'b0,
  output logic pwrite = 1'b0,
  output logic [15:0] paddr = 16'h0000,
  output logic [31:0] pwdata = 32'h0000_0000,
  // apb answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  // one transfer, held until pready is sampled high
  task automatic xfer(input logic wr, input logic [11:0] idx, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // both sync objects get one mode
  task automatic sync_same(input logic [7:0] m);
    logic [31:0] q;
    logic e;
    xfer(1'b1, sync_cfg_pkg::IDX_SYNC_OUT, {24'h000000, m}, q, e);
    xfer(1'b1, sync_cfg_pkg::IDX_SYNC_IN, {24'h000000, m}, q, e);
  endtask
endmodule

// File: test/sync_config_checker_test.sv
/*
  self-checking bench for the sync configuration checker.
  assumes the design package is compiled first and the master model beside it.
*/
module sync_config_checker_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, irq, err_led, rerr, v;
  logic [15:0] paddr, al_status_code;
  logic [31:0] pwdata, prdata, rdata;
  logic [3:0] esm_state;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  always #12.5 pclk = ~pclk;
  apb_master_model u_master(.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  sync_config_checker #(.BLINK_HALF_CYCLES(8)) u_dut(.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .err_led(err_led), .esm_state(esm_state), .al_status_code(al_status_code));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(input logic [11:0] idx, input logic [31:0] d);
    u_master.xfer(1'b1, idx, d, rdata, rerr);
  endtask
  task automatic rd(input logic [11:0] idx);
    u_master.xfer(1'b0, idx, 32'h0, rdata, rerr);
  endtask
  task automatic go(input logic [3:0] c);
    wr(sync_cfg_pkg::IDX_STATE_REQ, {28'h0, c});
    repeat (4) @(posedge pclk);
  endtask
  task automatic st(input logic [3:0] s, input logic [15:0] c);
    check({28'h0, esm_state}, {28'h0, s});
    check({16'h0, al_status_code}, {16'h0, c});
  endtask
  task automatic clr;
    wr(sync_cfg_pkg::IDX_ALARM_CLR, 32'h1);
    wr(sync_cfg_pkg::IDX_IRQ_CLR, 32'h7);
  endtask
  task automatic cfg;
    logic [11:0] ix [12] = '{12'h810, 12'h812, 12'h814, 12'h818, 12'h81a, 12'h81c, 12'ha02, 12'ha03,
      12'ha04, 12'ha06, 12'ha07, 12'ha08};
    logic [15:0] dv [12] = '{16'h1000, 16'h8, 16'h4, 16'h1100, 16'h8, 16'h0, 16'h800, 16'h40,
      16'h900, 16'h1000, 16'h1fff, 16'h8};
    for (int i = 0; i < 12; i++) wr(ix[i], {16'h0, dv[i]});
    wr(sync_cfg_pkg::IDX_TX_PDO, 32'h8);
    wr(sync_cfg_pkg::IDX_MBX1_LEN, 32'h40);
  endtask
  task automatic bad(input logic [11:0] ix, input logic [15:0] b, input logic [15:0] g, input logic [15:0] c);
    wr(ix, {16'h0, b});
    go(sync_cfg_pkg::ST_CODE_SAFEOP);
    st(sync_cfg_pkg::ST_CODE_PREOP, c);
    wr(ix, {16'h0, g});
    clr();
  endtask
  task automatic syn(input logic [7:0] o, input logic [7:0] i, input logic [7:0] a, input logic [15:0] c);
    wr(sync_cfg_pkg::IDX_SYNC_OUT, {24'h0, o});
    wr(sync_cfg_pkg::IDX_SYNC_IN, {24'h0, i});
    wr(sync_cfg_pkg::IDX_ACT, {24'h0, a});
    go(sync_cfg_pkg::ST_CODE_SAFEOP);
    st(c == 16'h0 ? sync_cfg_pkg::ST_CODE_SAFEOP : sync_cfg_pkg::ST_CODE_PREOP, c);
    go(sync_cfg_pkg::ST_CODE_PREOP);
    clr();
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      stop_test();
    end
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    st(sync_cfg_pkg::ST_CODE_PREOP, 16'h0);
    check({31'h0, err_led}, 32'h0);
    rd(sync_cfg_pkg::IDX_PD_HI);
    check(rdata, 32'h0000ffff);
    rd(sync_cfg_pkg::IDX_RX_CTL);
    check(rdata, 32'h0);
    rd(12'h100);
    check({31'h0, rerr}, 32'h1);
    cfg();
    u_master.sync_same(sync_cfg_pkg::SM_FREE);
    go(sync_cfg_pkg::ST_CODE_SAFEOP);
    st(sync_cfg_pkg::ST_CODE_SAFEOP, 16'h0);
    wr(sync_cfg_pkg::IDX_SYNC_OUT, 32'h3);
    go(sync_cfg_pkg::ST_CODE_OP);
    st(sync_cfg_pkg::ST_CODE_OP, 16'h0);
    wr(sync_cfg_pkg::IDX_IRQ_EN, 32'h7);
    wr(sync_cfg_pkg::IDX_RX_CTL, 32'h0);
    repeat (3) @(posedge pclk);
    st(sync_cfg_pkg::ST_CODE_PREOP, sync_cfg_pkg::AL_RX);
    check({31'h0, irq}, 32'h1);
    rd(sync_cfg_pkg::IDX_STATUS);
    check(rdata & 32'h30, 32'h20);
    v = err_led;
    repeat (8) @(posedge pclk);
    check({31'h0, err_led}, {31'h0, ~v});
    wr(sync_cfg_pkg::IDX_RX_CTL, 32'h4);
    wr(sync_cfg_pkg::IDX_TX_LEN, 32'h6);
    go(sync_cfg_pkg::ST_CODE_SAFEOP);
    st(sync_cfg_pkg::ST_CODE_PREOP, sync_cfg_pkg::AL_RX);
    wr(sync_cfg_pkg::IDX_TX_LEN, 32'h8);
    clr();
    repeat (2) @(posedge pclk);
    check({31'h0, irq}, 32'h0);
    check({16'h0, al_status_code}, 32'h0);
    syn(8'h03, 8'h00, 8'h00, sync_cfg_pkg::AL_SYNC);
    syn(8'h00, 8'h01, 8'h00, sync_cfg_pkg::AL_SYNC);
    syn(8'h01, 8'h00, 8'h00, sync_cfg_pkg::AL_SYNC);
    syn(8'h00, 8'h22, 8'h00, sync_cfg_pkg::AL_SYNC);
    syn(8'h01, 8'h22, 8'h00, 16'h0);
    syn(8'h02, 8'h02, 8'h00, 16'h0);
    syn(8'h00, 8'h22, 8'h03, 16'h0);
    u_master.sync_same(sync_cfg_pkg::SM_FREE);
    bad(12'h810, 16'h1001, 16'h1000, sync_cfg_pkg::AL_RX);
    bad(12'h818, 16'h1101, 16'h1100, sync_cfg_pkg::AL_TX);
    bad(12'h810, 16'h1100, 16'h1000, sync_cfg_pkg::AL_RX);
    bad(12'ha02, 16'h1000, 16'h800, sync_cfg_pkg::AL_RX);
    bad(12'h818, 16'h2100, 16'h1100, sync_cfg_pkg::AL_TX);
    bad(12'h812, 16'h6, 16'h8, sync_cfg_pkg::AL_RX);
    bad(12'h81a, 16'h6, 16'h8, sync_cfg_pkg::AL_TX);
    bad(12'h814, 16'h0, 16'h4, sync_cfg_pkg::AL_RX);
    bad(12'h81c, 16'h4, 16'h0, sync_cfg_pkg::AL_TX);
    stop_test();
  end
endmodule
